// ==== core/itbm_pkg.sv ====
// Shared constants and types of the ingress token bucket meter
`default_nettype none
package itbm_pkg;
    // Table geometry
    localparam int NUM_ENTRIES = 16;
    localparam int WORDS_PER_ENTRY = 4;
    localparam int CFG_W = 91;
    localparam int TOK_W = 16;
    localparam int NUM_TICKS = 5;
    localparam int TICK_PER_W = 16;
    localparam int IDX_W = 18;

    // Configuration entry field positions and widths
    localparam int CAP0_LSB = 0;
    localparam int INC0_LSB = 16;
    localparam int TSEL0_LSB = 28;
    localparam int CAP1_LSB = 31;
    localparam int INC1_LSB = 47;
    localparam int TSEL1_LSB = 59;
    localparam int MODE_BIT = 62;
    localparam int BLIND_BIT = 63;
    localparam int DROP_LSB = 64;
    localparam int LEN_LSB = 67;
    localparam int COST_LSB = 81;
    localparam int ADJ_LSB = 83;
    localparam int CAP_W = 16;
    localparam int INC_W = 12;
    localparam int TSEL_W = 3;
    localparam int LEN_W = 14;
    localparam int ADJ_W = 8;
    localparam int TOP_WORD_W = 27;

    // Register word indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_BLK_EN = 18'h14f90;
    localparam logic [IDX_W-1:0] IDX_BLOCKED = 18'h14fa0;
    localparam logic [IDX_W-1:0] IDX_CFG = 18'h14fb0;
    localparam logic [IDX_W-1:0] IDX_RELOAD = 18'h14ff0;
    localparam logic [IDX_W-1:0] IDX_STATUS = 18'h15000;
    localparam logic [IDX_W-1:0] IDX_TICK = 18'h15010;

    // Reset values
    localparam logic [CFG_W-1:0] CFG_RESET = (91'h4 << DROP_LSB) | (91'h3fff << LEN_LSB)
        | (91'h18 << ADJ_LSB);
    localparam logic RELOAD_RESET = 1'h1;

    // Default tick period: a time and its cycle count at the core clock
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_RST_CYC = (TICK_PERIOD_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [TICK_PER_W-1:0] TICK_PER_RESET = TICK_PER_W'(TICK_RST_CYC);

    // Colours, rate modes and token cost modes
    localparam logic [1:0] COL_GREEN = 2'h0;
    localparam logic [1:0] COL_YELLOW = 2'h1;
    localparam logic [1:0] COL_RED = 2'h2;
    localparam logic MODE_SINGLE = 1'h0;
    typedef enum logic [1:0] {COST_BYTES_ADD, COST_BYTES_SUB, COST_PACKETS, COST_NONE} itbm_cost_e;
endpackage : itbm_pkg
`default_nettype wire

// ==== core/itbm_tick_if.sv ====
// Tick period settings and tick pulses between register file and tick generator
`default_nettype none
interface itbm_tick_if;
    logic [itbm_pkg::NUM_TICKS-1:0][itbm_pkg::TICK_PER_W-1:0] period;
    logic [itbm_pkg::NUM_TICKS-1:0] tick;
    modport gen (input period, output tick);
    modport user (output period, input tick);
endinterface : itbm_tick_if
`default_nettype wire

// ==== core/itbm_tick_gen.sv ====
// Generator of the five global refill ticks
`default_nettype none
module itbm_tick_gen (
    input wire logic clk_i,
    input wire logic nrst_i,
    itbm_tick_if.gen tif
);
    logic [itbm_pkg::NUM_TICKS-1:0][itbm_pkg::TICK_PER_W-1:0] cnt_ff;
    logic [itbm_pkg::NUM_TICKS-1:0] tick_ff;

    assign tif.tick = tick_ff;

    // One pulse every period cycles; period zero stops the tick
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnt_ff <= '0;
            tick_ff <= '0;
        end else begin
            for (int i = 0; i < itbm_pkg::NUM_TICKS; i++) begin
                if (tif.period[i] == '0) begin
                    cnt_ff[i] <= '0;
                    tick_ff[i] <= 1'b0;
                end else if (cnt_ff[i] >= tif.period[i] - 16'h1) begin // Shrunk period wraps
                    cnt_ff[i] <= '0;
                    tick_ff[i] <= 1'b1;
                end else begin
                    cnt_ff[i] <= cnt_ff[i] + 16'h1;
                    tick_ff[i] <= 1'b0;
                end
            end
        end
    end

    a_tick_gap: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tick_ff[0] && tif.period[0] > 16'h1 && $stable(tif.period[0]) |=> !tick_ff[0])
        else $error("tick 0 pulsed twice in a row");
endmodule : itbm_tick_gen
`default_nettype wire

// ==== core/itbm_meter.sv ====
// Ingress token bucket meter: 16 entries, APB register file, per packet verdict
//
// Register access over APB is this design's own decision.
`default_nettype none
module itbm_meter #(
    parameter int NUM_ENTRIES = itbm_pkg::NUM_ENTRIES,
    parameter int PKT_LEN_W = 16
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [19:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic pkt_valid_i,
    input wire logic [3:0] pkt_ptr_i,
    input wire logic [PKT_LEN_W-1:0] pkt_len_i,
    input wire logic [1:0] pkt_colour_i,
    output logic res_valid_o,
    output logic res_drop_o,
    output logic [1:0] res_colour_o,
    output logic [3:0] res_ptr_o
);
    localparam int TW = itbm_pkg::TOK_W;

    logic [itbm_pkg::CFG_W-1:0] cfg_ff [NUM_ENTRIES];
    logic [TW-1:0] tok_ff [NUM_ENTRIES][2];
    logic [TW-1:0] nxt_tok [NUM_ENTRIES][2];
    logic [TW-1:0] refill [NUM_ENTRIES][2];
    logic [NUM_ENTRIES-1:0] reload_ff;
    logic [NUM_ENTRIES-1:0] blocked_ff;
    logic [NUM_ENTRIES-1:0] blk_en_ff;
    logic [itbm_pkg::NUM_TICKS-1:0][itbm_pkg::TICK_PER_W-1:0] tick_per_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic res_valid_ff;
    logic res_drop_ff;
    logic [1:0] res_colour_ff;
    logic [3:0] res_ptr_ff;

    itbm_tick_if tick_bus ();

    itbm_tick_gen u_tick (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .tif(tick_bus.gen)
    );

    assign tick_bus.period = tick_per_ff;

    // Saturating refill
    function automatic logic [TW-1:0] sat_add(input logic [TW-1:0] tok,
                                              input logic [itbm_pkg::INC_W-1:0] inc,
                                              input logic [TW-1:0] cap);
        logic [TW:0] sum;
        sum = {1'b0, tok} + {5'h0, inc};
        return (sum > {1'b0, cap}) ? cap : sum[TW-1:0];
    endfunction : sat_add

    // Selected tick fires; codes 5..7 select no tick
    function automatic logic tick_fire(input logic [itbm_pkg::TSEL_W-1:0] sel,
                                       input logic [itbm_pkg::NUM_TICKS-1:0] ticks);
        return (int'(sel) < itbm_pkg::NUM_TICKS) && ticks[sel];
    endfunction : tick_fire

    // Word index inside [base, base + span)
    function automatic logic reg_hit(input logic [17:0] idx, input logic [17:0] base,
                                     input logic [17:0] span);
        return (idx >= base) && (idx < base + span);
    endfunction : reg_hit

    // Token cost of one packet
    function automatic logic [TW-1:0] cost_of(input logic [1:0] mode,
                                              input logic [PKT_LEN_W-1:0] len,
                                              input logic [itbm_pkg::ADJ_W-1:0] adj);
        logic [PKT_LEN_W:0] sum;
        sum = '0;
        unique case (itbm_pkg::itbm_cost_e'(mode))
            itbm_pkg::COST_BYTES_ADD: sum = {1'b0, len} + {9'h0, adj};
            itbm_pkg::COST_BYTES_SUB: begin
                sum = (len > PKT_LEN_W'(adj)) ? {1'b0, len} - {9'h0, adj} : '0;
            end
            itbm_pkg::COST_PACKETS: sum = 17'h1;
            itbm_pkg::COST_NONE: sum = '0;
        endcase
        return sum[PKT_LEN_W] ? '1 : sum[TW-1:0];
    endfunction : cost_of

    // APB decode
    logic [17:0] widx;
    logic [17:0] roff;
    logic [3:0] rent;
    logic hit_cfg;
    logic hit_stat;
    logic hit_rel;
    logic hit_blk;
    logic hit_en;
    logic hit_tick;
    logic apb_wr;
    logic [31:0] rd_data;

    assign widx = paddr_i[19:2];
    assign apb_wr = psel_i && penable_i && pready_ff && pwrite_i;

    // Entry tables sit at word index base plus entry number; the configuration table at base plus four words per entry
    always_comb begin
        hit_cfg = reg_hit(widx, itbm_pkg::IDX_CFG, 18'h40);
        hit_stat = reg_hit(widx, itbm_pkg::IDX_STATUS, 18'h10);
        hit_rel = reg_hit(widx, itbm_pkg::IDX_RELOAD, 18'h10);
        hit_blk = reg_hit(widx, itbm_pkg::IDX_BLOCKED, 18'h10);
        hit_en = reg_hit(widx, itbm_pkg::IDX_BLK_EN, 18'h10);
        hit_tick = reg_hit(widx, itbm_pkg::IDX_TICK, 18'h5);
        roff = '0;
        if (hit_cfg) begin
            roff = (widx - itbm_pkg::IDX_CFG) >> 2;
        end else if (hit_stat) begin
            roff = widx - itbm_pkg::IDX_STATUS;
        end else if (hit_rel) begin
            roff = widx - itbm_pkg::IDX_RELOAD;
        end else if (hit_blk) begin
            roff = widx - itbm_pkg::IDX_BLOCKED;
        end else if (hit_en) begin
            roff = widx - itbm_pkg::IDX_BLK_EN;
        end else if (hit_tick) begin
            roff = widx - itbm_pkg::IDX_TICK;
        end
        rent = roff[3:0];
    end

    // Read mux; narrow registers read zero above their field
    always_comb begin
        rd_data = '0;
        if (hit_cfg) begin
            unique case (widx[1:0])
                2'h0: rd_data = cfg_ff[rent][31:0];
                2'h1: rd_data = cfg_ff[rent][63:32];
                2'h2: rd_data = {5'h0, cfg_ff[rent][90:64]};
                2'h3: rd_data = '0;
            endcase
        end else if (hit_stat) begin
            rd_data = {tok_ff[rent][1], tok_ff[rent][0]};
        end else if (hit_rel) begin
            rd_data = {31'h0, reload_ff[rent]};
        end else if (hit_blk) begin
            rd_data = {31'h0, blocked_ff[rent]};
        end else if (hit_en) begin
            rd_data = {31'h0, blk_en_ff[rent]};
        end else if (hit_tick) begin
            rd_data = {16'h0, tick_per_ff[rent[2:0]]};
        end
    end

    // APB answer: data caught in setup, ready in the first access cycle
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else if (psel_i && !penable_i) begin
            prdata_ff <= pwrite_i ? 32'h0 : rd_data;
            pready_ff <= 1'b1;
            pslverr_ff <= !(hit_cfg || hit_stat || hit_rel || hit_blk || hit_en || hit_tick);
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // Configuration table writes, top word keeps only its 27 bits
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            for (int e = 0; e < NUM_ENTRIES; e++) begin
                cfg_ff[e] <= itbm_pkg::CFG_RESET;
            end
        end else if (apb_wr && hit_cfg) begin
            unique case (widx[1:0])
                2'h0: cfg_ff[rent][31:0] <= pwdata_i;
                2'h1: cfg_ff[rent][63:32] <= pwdata_i;
                2'h2: cfg_ff[rent][90:64] <= pwdata_i[itbm_pkg::TOP_WORD_W-1:0];
                2'h3: ;
            endcase
        end
    end

    // Tick periods and block-on-drop enables
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tick_per_ff <= {itbm_pkg::NUM_TICKS{itbm_pkg::TICK_PER_RESET}};
            blk_en_ff <= '0;
        end else if (apb_wr) begin
            if (hit_tick) begin
                tick_per_ff[rent[2:0]] <= pwdata_i[15:0];
            end
            if (hit_en) begin
                blk_en_ff[rent] <= pwdata_i[0];
            end
        end
    end

    // Per bucket refill on its chosen tick
    always_comb begin
        for (int e = 0; e < NUM_ENTRIES; e++) begin
            refill[e][0] = tok_ff[e][0];
            refill[e][1] = tok_ff[e][1];
            if (tick_fire(cfg_ff[e][itbm_pkg::TSEL0_LSB +: itbm_pkg::TSEL_W], tick_bus.tick)) begin
                refill[e][0] = sat_add(tok_ff[e][0], cfg_ff[e][itbm_pkg::INC0_LSB +: 12],
                                       cfg_ff[e][itbm_pkg::CAP0_LSB +: 16]);
            end
            if (tick_fire(cfg_ff[e][itbm_pkg::TSEL1_LSB +: itbm_pkg::TSEL_W], tick_bus.tick)) begin
                refill[e][1] = sat_add(tok_ff[e][1], cfg_ff[e][itbm_pkg::INC1_LSB +: 12],
                                       cfg_ff[e][itbm_pkg::CAP1_LSB +: 16]);
            end
        end
    end

    // Fields of the visited entry
    logic [itbm_pkg::CFG_W-1:0] vcfg;
    logic [TW-1:0] cap0;
    logic [TW-1:0] cap1;
    logic [TW-1:0] b0;
    logic [TW-1:0] b1;
    logic [TW-1:0] cost;
    logic [1:0] in_col;
    logic oversize;
    logic met;
    logic ok0;
    logic ok1;
    logic take0;
    logic take1;
    logic [1:0] col;
    logic drop;

    assign vcfg = cfg_ff[pkt_ptr_i];
    assign cap0 = vcfg[itbm_pkg::CAP0_LSB +: itbm_pkg::CAP_W];
    assign cap1 = vcfg[itbm_pkg::CAP1_LSB +: itbm_pkg::CAP_W];
    // Pending reload meters against full buckets
    assign b0 = reload_ff[pkt_ptr_i] ? cap0 : refill[pkt_ptr_i][0];
    assign b1 = reload_ff[pkt_ptr_i] ? cap1 : refill[pkt_ptr_i][1];
    assign cost = cost_of(vcfg[itbm_pkg::COST_LSB +: 2], pkt_len_i,
                          vcfg[itbm_pkg::ADJ_LSB +: itbm_pkg::ADJ_W]);
    // Colour-blind metering is aware metering of a green packet
    assign in_col = vcfg[itbm_pkg::BLIND_BIT] ? itbm_pkg::COL_GREEN : pkt_colour_i;
    assign oversize = pkt_len_i > PKT_LEN_W'(vcfg[itbm_pkg::LEN_LSB +: itbm_pkg::LEN_W]);
    assign met = !blocked_ff[pkt_ptr_i] && !oversize;
    assign ok0 = cost <= b0;
    assign ok1 = cost <= b1;

    // Marker decision; bucket 0 is committed in both modes
    always_comb begin
        col = itbm_pkg::COL_RED;
        take0 = 1'b0;
        take1 = 1'b0;
        if (vcfg[itbm_pkg::MODE_BIT] == itbm_pkg::MODE_SINGLE) begin
            if (in_col == itbm_pkg::COL_GREEN && ok0) begin
                col = itbm_pkg::COL_GREEN;
                take0 = 1'b1;
            end else if (in_col <= itbm_pkg::COL_YELLOW && ok1) begin
                col = itbm_pkg::COL_YELLOW;
                take1 = 1'b1;
            end
        end else begin
            if (in_col >= itbm_pkg::COL_RED || !ok1) begin
                col = itbm_pkg::COL_RED;
            end else if (in_col == itbm_pkg::COL_YELLOW || !ok0) begin
                col = itbm_pkg::COL_YELLOW;
                take1 = 1'b1;
            end else begin
                col = itbm_pkg::COL_GREEN;
                take0 = 1'b1;
                take1 = 1'b1;
            end
        end
        if (!met) begin
            col = itbm_pkg::COL_RED;
        end
        drop = !met || vcfg[itbm_pkg::DROP_LSB + int'(col)];
    end

    // Next token counts: refill everywhere, charge only the visited entry
    always_comb begin
        for (int e = 0; e < NUM_ENTRIES; e++) begin
            nxt_tok[e][0] = refill[e][0];
            nxt_tok[e][1] = refill[e][1];
        end
        if (pkt_valid_i) begin
            nxt_tok[pkt_ptr_i][0] = (met && take0) ? b0 - cost : b0;
            nxt_tok[pkt_ptr_i][1] = (met && take1) ? b1 - cost : b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            for (int e = 0; e < NUM_ENTRIES; e++) begin
                tok_ff[e][0] <= '0;
                tok_ff[e][1] <= '0;
            end
        end else begin
            tok_ff <= nxt_tok;
        end
    end

    // Reload bit: cleared by the visit, a software write in the same cycle wins
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            reload_ff <= {NUM_ENTRIES{itbm_pkg::RELOAD_RESET}};
        end else begin
            if (pkt_valid_i) begin
                reload_ff[pkt_ptr_i] <= 1'b0;
            end
            if (apb_wr && hit_rel) begin
                reload_ff[rent] <= pwdata_i[0];
            end
        end
    end

    // Blocked flag: hardware set beats a software clear
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            blocked_ff <= '0;
        end else begin
            if (apb_wr && hit_blk) begin
                blocked_ff[rent] <= pwdata_i[0];
            end
            if (pkt_valid_i && drop && blk_en_ff[pkt_ptr_i]) begin
                blocked_ff[pkt_ptr_i] <= 1'b1;
            end
        end
    end

    // Verdict one cycle after the packet
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            res_valid_ff <= 1'b0;
            res_drop_ff <= 1'b0;
            res_colour_ff <= itbm_pkg::COL_GREEN;
            res_ptr_ff <= '0;
        end else begin
            res_valid_ff <= pkt_valid_i;
            res_drop_ff <= pkt_valid_i && drop;
            res_colour_ff <= pkt_valid_i ? col : itbm_pkg::COL_GREEN;
            res_ptr_ff <= pkt_valid_i ? pkt_ptr_i : 4'h0;
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign res_valid_o = res_valid_ff;
    assign res_drop_o = res_drop_ff;
    assign res_colour_o = res_colour_ff;
    assign res_ptr_o = res_ptr_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_long_visit;
        pkt_valid_i && !blocked_ff[pkt_ptr_i] && oversize;
    endsequence

    sequence s_dropped_verdict;
        res_valid_o ##0 res_drop_o;
    endsequence

    a_len_drop: assert property (s_long_visit |=> s_dropped_verdict)
        else $error("oversize packet not dropped");
    a_reload_clear: assert property (pkt_valid_i && !apb_wr |=>
        !reload_ff[$past(pkt_ptr_i)]) else $error("reload not cleared by visit");
    a_blocked_drop: assert property (pkt_valid_i && blocked_ff[pkt_ptr_i] |=>
        res_drop_o && res_colour_o == itbm_pkg::COL_RED) else $error("blocked entry passed");
    a_block_set: assert property (res_valid_o && res_drop_o && $past(blk_en_ff[pkt_ptr_i])
        |-> blocked_ff[res_ptr_o]) else $error("drop did not block entry");
    a_drop_mask: assert property (pkt_valid_i && met && !apb_wr |=>
        res_drop_o == $past(vcfg[itbm_pkg::DROP_LSB + int'(col)])) else $error("mask mismatch");
    a_tok_bound: assert property (pkt_valid_i && reload_ff[pkt_ptr_i] && !apb_wr |=>
        tok_ff[$past(pkt_ptr_i)][0] <= $past(cap0)) else $error("bucket above capacity");
    a_aware_red: assert property (pkt_valid_i && met && !vcfg[itbm_pkg::BLIND_BIT]
        && pkt_colour_i == itbm_pkg::COL_RED |=> res_colour_o == itbm_pkg::COL_RED)
        else $error("red packet recoloured");
    a_idle_verdict: assert property (!pkt_valid_i |=> !res_valid_o && !res_drop_o)
        else $error("verdict without packet");
endmodule : itbm_meter
`default_nettype wire

// ==== tb/itbm_pipe_model.sv ====
// Ingress pipeline model that hands packets to the meter
`default_nettype none
module itbm_pipe_model (
    input wire logic clk_i,
    output logic pkt_valid_o,
    output logic [3:0] pkt_ptr_o,
    output logic [15:0] pkt_len_o,
    output logic [1:0] pkt_colour_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle at time zero
    initial begin
        pkt_valid_o = 1'b0;
        pkt_ptr_o = 4'h0;
        pkt_len_o = 16'h0;
        pkt_colour_o = 2'h0;
    end
    // One packet per call; fields invert afterwards so stale values never pass
    task automatic send(input logic [3:0] p, input logic [15:0] l, input logic [1:0] c);
        @(posedge clk_i);
        pkt_valid_o <= 1'b1;
        pkt_ptr_o <= p;
        pkt_len_o <= l;
        pkt_colour_o <= c;
        @(posedge clk_i);
        pkt_valid_o <= 1'b0;
        pkt_ptr_o <= ~p;
        pkt_len_o <= ~l;
        pkt_colour_o <= ~c;
    endtask : send
endmodule : itbm_pipe_model
`default_nettype wire

// ==== tb/tb_itbm_meter.sv ====
// Self-checking bench for the ingress token bucket meter
`default_nettype none
module tb_itbm_meter;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [19:0] paddr_i = 20'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o, rd;
    logic pready_o, pslverr_o, err, pkt_valid_i, res_valid_o, res_drop_o;
    logic [3:0] pkt_ptr_i, res_ptr_o;
    logic [15:0] pkt_len_i;
    logic [1:0] pkt_colour_i, res_colour_o;
    int n_fail = 0;
    int checked = 0;

    itbm_meter itbm_meter_inst (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .pkt_valid_i(pkt_valid_i), .pkt_ptr_i(pkt_ptr_i), .pkt_len_i(pkt_len_i),
        .pkt_colour_i(pkt_colour_i), .res_valid_o(res_valid_o), .res_drop_o(res_drop_o),
        .res_colour_o(res_colour_o), .res_ptr_o(res_ptr_o));
    itbm_pipe_model itbm_pipe_model_inst (.clk_i(clk_i), .pkt_valid_o(pkt_valid_i),
        .pkt_ptr_o(pkt_ptr_i), .pkt_len_o(pkt_len_i), .pkt_colour_o(pkt_colour_i));

    // 200 MHz clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // APB transfer; request held until pready is sampled high, only the watchdog ends a wait
    task automatic apb(input logic wr, input logic [17:0] idx, input logic [31:0] wd);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= {idx, 2'h0};
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // Answer taken at the same rising edge that shows pready high
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    // Send one packet and judge the verdict one cycle later
    task automatic pkt(input logic [3:0] p, input logic [15:0] l, input logic [1:0] c,
                       input logic dr, input logic [1:0] ec);
        itbm_pipe_model_inst.send(p, l, c);
        #1;
        chk("res_valid", 32'h1, {31'h0, res_valid_o});
        chk("res_drop", {31'h0, dr}, {31'h0, res_drop_o});
        chk("res_colour", {30'h0, ec}, {30'h0, res_colour_o});
        chk("res_ptr", {28'h0, p}, {28'h0, res_ptr_o});
    endtask : pkt

    task automatic t_reset;
        apb(1'b0, itbm_pkg::IDX_CFG + 18'h2, 32'h0);
        chk("cfg_w2", 32'h00c1fffc, rd);
        apb(1'b0, itbm_pkg::IDX_RELOAD, 32'h0);
        chk("reload", 32'h1, rd);
        apb(1'b0, itbm_pkg::IDX_TICK, 32'h0);
        chk("tick_per", 32'h000000c8, rd);
        apb(1'b0, 18'h0, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        pkt(4'h0, 16'h4000, 2'h0, 1'b1, 2'h2);
    endtask : t_reset

    // Entry 1 srTCM, committed cap 100, second cap 50, no refill
    task automatic t_srtcm;
        apb(1'b1, itbm_pkg::IDX_CFG + 18'h4, 32'h70000064);
        apb(1'b1, itbm_pkg::IDX_CFG + 18'h5, 32'h38000019);
        pkt(4'h1, 16'd60, 2'h0, 1'b0, 2'h0);
        pkt(4'h1, 16'd30, 2'h0, 1'b1, 2'h2);
        pkt(4'h1, 16'd2, 2'h1, 1'b0, 2'h1);
        apb(1'b0, itbm_pkg::IDX_STATUS + 18'h1, 32'h0);
        chk("tokens", 32'h00180010, rd);
        apb(1'b1, itbm_pkg::IDX_RELOAD + 18'h1, 32'h1);
        apb(1'b1, itbm_pkg::IDX_CFG + 18'h6, 32'h00c5fffc);
        apb(1'b1, itbm_pkg::IDX_CFG + 18'h5, 32'hb8000019);
        pkt(4'h1, 16'd500, 2'h1, 1'b0, 2'h0);
        apb(1'b0, itbm_pkg::IDX_STATUS + 18'h1, 32'h0);
        chk("tokens", 32'h00320063, rd);
    endtask : t_srtcm

    // Entry 3 trTCM, committed cap 10, peak cap 100
    task automatic t_trtcm;
        apb(1'b1, itbm_pkg::IDX_CFG + 18'hc, 32'h7000000a);
        apb(1'b1, itbm_pkg::IDX_CFG + 18'hd, 32'h78000032);
        pkt(4'h3, 16'd0, 2'h0, 1'b0, 2'h1);
        pkt(4'h3, 16'd80, 2'h0, 1'b1, 2'h2);
        pkt(4'h3, 16'd0, 2'h2, 1'b1, 2'h2);
    endtask : t_trtcm

    // Entry 4 refills from tick 0 up to its cap; bucket 1 selects no tick
    task automatic t_refill;
        apb(1'b1, itbm_pkg::IDX_CFG + 18'h10, 32'h001e0064);
        apb(1'b1, itbm_pkg::IDX_CFG + 18'h11, 32'h280f0032);
        repeat (1000) @(posedge clk_i);
        apb(1'b0, itbm_pkg::IDX_STATUS + 18'h4, 32'h0);
        chk("refill", 32'h00000064, rd);
        apb(1'b1, itbm_pkg::IDX_CFG + 18'h12, 32'h00c3fffc);
        pkt(4'h4, 16'd110, 2'h0, 1'b0, 2'h0);
        apb(1'b1, itbm_pkg::IDX_CFG + 18'h12, 32'h00c7fffc);
        pkt(4'h4, 16'd200, 2'h0, 1'b0, 2'h0);
    endtask : t_refill

    // Entry 2 drops green and blocks until cleared
    task automatic t_block;
        apb(1'b1, itbm_pkg::IDX_CFG + 18'h8, 32'h7000ffff);
        apb(1'b1, itbm_pkg::IDX_CFG + 18'ha, 32'h00c1fff9);
        apb(1'b1, itbm_pkg::IDX_BLK_EN + 18'h2, 32'h1);
        pkt(4'h2, 16'd10, 2'h0, 1'b1, 2'h0);
        pkt(4'h2, 16'd10, 2'h0, 1'b1, 2'h2);
        apb(1'b0, itbm_pkg::IDX_BLOCKED + 18'h2, 32'h0);
        chk("blocked", 32'h1, rd);
        apb(1'b1, itbm_pkg::IDX_BLK_EN + 18'h2, 32'h0);
        apb(1'b1, itbm_pkg::IDX_BLOCKED + 18'h2, 32'h0);
        pkt(4'h2, 16'd10, 2'h0, 1'b1, 2'h0);
    endtask : t_block

    task automatic wrap_up;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // Reset for 3 cycles, then the scenarios
    initial begin
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_srtcm();
        t_trtcm();
        t_refill();
        t_block();
        wrap_up();
    end

    // Watchdog well beyond the refill wait and the hundred or so other cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        wrap_up();
    end
endmodule : tb_itbm_meter
`default_nettype wire
